/* File: rtl/timer_channel_capture_compare.sv */
// Purpose: mode, pin and register logic of six timer capture/compare channels
// Assumes: shared counter gives value, tick and overflow; sole AHB-Lite slave
// Notes:   reads take one wait state, writes none
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module timer_channel_capture_compare
    import tcc_pkg::*;
(
    input  wire logic                hclk,         // bus clock
    input  wire logic                hresetn,      // async reset, low
    input  wire logic                hsel,         // slave select
    input  wire logic [31:0]         haddr,        // byte address
    input  wire logic [1:0]          htrans,       // transfer type
    input  wire logic                hwrite,       // write when high
    input  wire logic [2:0]          hsize,        // word only
    input  wire logic [31:0]         hwdata,       // write data
    input  wire logic                hready,       // bus ready
    output logic      [31:0]         hrdata,       // read data
    output logic                     hreadyout,    // slave ready
    output logic                     hresp,        // always okay
    input  wire logic [VAL_W-1:0]    cnt_value,    // shared counter value
    input  wire logic                cnt_tick,     // counter moved this cycle
    input  wire logic                cnt_ovf,      // counter wrapped, pulse
    input  wire logic                counter_halt, // counter stopped
    input  wire logic [NUM_CHAN-1:0] chan_pin_in,  // pin levels, async
    output logic      [NUM_CHAN-1:0] chan_pin_out, // pin drive level
    output logic      [NUM_CHAN-1:0] chan_pin_oe,  // channel owns pin
    output logic      [NUM_CHAN-1:0] chan_irq      // interrupt requests
);

    ////////////////////////////////////////////////////////////////////////
    // state

    bus_state_type       bus_reg;
    bus_state_type       bus_next;
    addr_type            adr_reg;
    addr_type            adr_next;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic                ready_reg;
    logic                ready_next;
    logic                resp_reg;
    ctrl_type            ctrl_reg [NUM_CHAN];
    ctrl_type            ctrl_next [NUM_CHAN];
    logic [VAL_W-1:0]    val_reg [NUM_CHAN];
    logic [VAL_W-1:0]    val_next [NUM_CHAN];
    logic [NUM_CHAN-1:0] out_reg;
    logic [NUM_CHAN-1:0] out_next;
    logic [NUM_CHAN-1:0] oe_reg;
    logic [NUM_CHAN-1:0] oe_next;
    logic [NUM_CHAN-1:0] irq_reg;
    logic [NUM_CHAN-1:0] irq_next;
    logic [NUM_CHAN-1:0] arm_reg;
    logic [NUM_CHAN-1:0] arm_next;
    logic [NUM_CHAN-1:0] cap_blk_reg;
    logic [NUM_CHAN-1:0] cap_blk_next;
    logic [NUM_CHAN-1:0] cmp_blk_reg;
    logic [NUM_CHAN-1:0] cmp_blk_next;
    logic [NUM_CHAN-1:0] fdty_reg;
    logic [NUM_CHAN-1:0] fdty_next;
    logic [NUM_CHAN-1:0] pin_reg;
    logic [NUM_CHAN-1:0] pin_next;
    logic [NUM_CHAN-1:0] sync1_reg;
    logic [NUM_CHAN-1:0] sync2_reg;
    logic [NUM_CHAN-1:0] sync3_reg;
    logic [NUM_PAIR-1:0] sel_reg;
    logic [NUM_PAIR-1:0] sel_next;
    logic [NUM_PAIR-1:0] lastw_reg;
    logic [NUM_PAIR-1:0] lastw_next;
    logic [NUM_CHAN-1:0] off;
    logic [NUM_CHAN-1:0] cap_ev;
    logic [NUM_CHAN-1:0] cmp_ev;

    assign hrdata       = rdata_reg;
    assign hreadyout    = ready_reg;
    assign hresp        = resp_reg;
    assign chan_pin_out = out_reg;
    assign chan_pin_oe  = oe_reg;
    assign chan_irq     = irq_reg;

    // odd channel of a buffered pair is switched off
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_off
        if (g % 2 == 1) begin : g_odd
            assign off[g] = ctrl_reg[g-1].buffered_mode_select;
        end else begin : g_even
            assign off[g] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    always_comb begin
        bus_next   = B_IDLE;
        adr_next   = adr_reg;
        rdata_next = rdata_reg;
        ready_next = 1'b1;
        if (bus_reg == B_RD) begin
            rdata_next = 32'h0000_0000;
            if (adr_reg.chan <= CHAN_LAST) begin
                unique case (adr_reg.ofs)
                    CTRL_OFS: rdata_next[7:0] = off[adr_reg.chan] ? 8'h00 : ctrl_reg[adr_reg.chan];
                    VHI_OFS:  rdata_next[7:0] = val_reg[adr_reg.chan][15:8];
                    VLO_OFS:  rdata_next[7:0] = val_reg[adr_reg.chan][7:0];
                    default:  rdata_next[7:0] = 8'h00;
                endcase
            end
        end
        if (hsel && htrans[1] && hready) begin
            adr_next   = '{chan: haddr[6:4], ofs: haddr[3:0]};
            bus_next   = hwrite ? B_WR : B_RD;
            ready_next = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg   <= B_IDLE;
            adr_reg   <= '0;
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end else begin
            bus_reg   <= bus_next;
            adr_reg   <= adr_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            resp_reg  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channels

    always_comb begin
        ctrl_type c;
        ctrl_type w;
        logic     wsel;
        logic     rsel;
        logic     chg;
        logic     hit;
        logic     o;
        int       p;
        c            = CTRL_RST;
        w            = CTRL_RST;
        wsel         = 1'b0;
        rsel         = 1'b0;
        chg          = 1'b0;
        hit          = 1'b0;
        o            = 1'b0;
        p            = 0;
        ctrl_next    = ctrl_reg;
        val_next     = val_reg;
        out_next     = out_reg;
        oe_next      = oe_reg;
        irq_next     = irq_reg;
        arm_next     = arm_reg;
        cap_blk_next = cap_blk_reg;
        cmp_blk_next = cmp_blk_reg;
        fdty_next    = fdty_reg;
        pin_next     = pin_reg;
        sel_next     = sel_reg;
        lastw_next   = lastw_reg;
        cap_ev       = '0;
        cmp_ev       = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            c    = off[i] ? CTRL_RST : ctrl_reg[i];
            wsel = bus_reg == B_WR && adr_reg.chan == 3'(i);
            rsel = bus_reg == B_RD && adr_reg.chan == 3'(i);
            // a pin change counts once stages two and three agree
            chg  = sync2_reg[i] == sync3_reg[i] && sync3_reg[i] != pin_reg[i];
            if (chg) begin
                pin_next[i] = sync3_reg[i];
            end
            hit = 1'b0;
            if (c.edge_level == EL_RISE_TGL) begin
                hit = chg && sync3_reg[i];
            end else if (c.edge_level == EL_FALL_CLR) begin
                hit = chg && !sync3_reg[i];
            end else if (c.edge_level == EL_ANY_SET) begin
                hit = chg;
            end
            cap_ev[i] = is_cap(c) && hit && !counter_halt && !cap_blk_reg[i];
            p = i;
            if (c.buffered_mode_select) begin
                p = i + int'(sel_reg[i/2]);
            end
            cmp_ev[i] = is_cmp(c) && cnt_tick && cnt_value == val_reg[p]
                        && !cmp_blk_reg[p];
            if (cap_ev[i]) begin
                val_next[i] = cnt_value;
            end
            if (wsel && adr_reg.ofs == VHI_OFS) begin
                val_next[i][15:8] = hwdata[7:0];
                cmp_blk_next[i]   = !is_cap(c);
            end
            if (wsel && adr_reg.ofs == VLO_OFS) begin
                val_next[i][7:0] = hwdata[7:0];
                cmp_blk_next[i]  = 1'b0;
                lastw_next[i/2]  = i[0];
            end
            if (rsel && adr_reg.ofs == VHI_OFS && is_cap(c)) begin
                cap_blk_next[i] = 1'b1;
            end
            if (rsel && adr_reg.ofs == VLO_OFS) begin
                cap_blk_next[i] = 1'b0;
            end
            if (rsel && adr_reg.ofs == CTRL_OFS && ctrl_reg[i].chan_event_flag && !off[i]) begin
                arm_next[i] = 1'b1;
            end
            if (wsel && adr_reg.ofs == CTRL_OFS && !off[i]) begin
                w = ctrl_type'(hwdata[7:0]);
                w.chan_event_flag      = ctrl_reg[i].chan_event_flag
                                         && !(arm_reg[i] && !w.chan_event_flag);
                w.buffered_mode_select = w.buffered_mode_select && !i[0];
                ctrl_next[i]           = w;
                arm_next[i]            = 1'b0;
            end
            if (cap_ev[i] || cmp_ev[i]) begin
                ctrl_next[i].chan_event_flag = 1'b1;
            end
            if (cnt_ovf) begin
                fdty_next[i] = c.force_full_duty && !c.toggle_on_overflow;
            end
            o = out_reg[i];
            if (c.edge_level == EL_NONE) begin
                o = !c.mode_select_a;
            end else if (is_cmp(c)) begin
                if (cnt_ovf && c.toggle_on_overflow) begin
                    o = !o;
                end else if (cmp_ev[i]) begin
                    unique case (c.edge_level)
                        EL_FALL_CLR: o = 1'b0;
                        EL_ANY_SET:  o = 1'b1;
                        default:     o = !o;
                    endcase
                end
                if (fdty_next[i]) begin
                    o = c.edge_level != EL_ANY_SET;
                end
            end
            out_next[i] = o;
            oe_next[i]  = is_cmp(c);
            irq_next[i] = ctrl_next[i].chan_event_flag && ctrl_next[i].chan_irq_enable
                          && !off[i];
        end
        for (int k = 0; k < NUM_PAIR; k++) begin
            if (cnt_ovf) begin
                sel_next[k] = lastw_next[k];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg    <= '{default: CTRL_RST};
            val_reg     <= '{default: '0};
            out_reg     <= '0;
            oe_reg      <= '0;
            irq_reg     <= '0;
            arm_reg     <= '0;
            cap_blk_reg <= '0;
            cmp_blk_reg <= '0;
            fdty_reg    <= '0;
            pin_reg     <= '0;
            sync1_reg   <= '0;
            sync2_reg   <= '0;
            sync3_reg   <= '0;
            sel_reg     <= '0;
            lastw_reg   <= '0;
        end else begin
            ctrl_reg    <= ctrl_next;
            val_reg     <= val_next;
            out_reg     <= out_next;
            oe_reg      <= oe_next;
            irq_reg     <= irq_next;
            arm_reg     <= arm_next;
            cap_blk_reg <= cap_blk_next;
            cmp_blk_reg <= cmp_blk_next;
            fdty_reg    <= fdty_next;
            pin_reg     <= pin_next;
            sync1_reg   <= chan_pin_in;
            sync2_reg   <= sync1_reg;
            sync3_reg   <= sync2_reg;
            sel_reg     <= sel_next;
            lastw_reg   <= lastw_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic wr_ctrl0;
    assign wr_ctrl0 = bus_reg == B_WR && adr_reg.chan == 3'h0 && adr_reg.ofs == CTRL_OFS;

    a_irq_gate: assert property (
        !ctrl_reg[0].chan_irq_enable |-> !chan_irq[0])
        else $error("channel 0 interrupt without enable");

    a_odd_nobuf: assert property (
        !(ctrl_reg[1].buffered_mode_select || ctrl_reg[3].buffered_mode_select
          || ctrl_reg[5].buffered_mode_select))
        else $error("buffered select bit set on odd channel");

    a_odd_release: assert property (
        ctrl_reg[4].buffered_mode_select |=> !chan_pin_oe[5])
        else $error("odd channel keeps pin in buffered pair");

    a_preset_out: assert property (
        ctrl_reg[0].edge_level == EL_NONE
        |=> chan_pin_out[0] == !$past(ctrl_reg[0].mode_select_a))
        else $error("preset level wrong");

    a_port_owns: assert property (
        ctrl_reg[0].edge_level == EL_NONE |=> !chan_pin_oe[0])
        else $error("pin driven with edge/level clear");

    a_cap_block: assert property (
        cap_blk_reg[2] && is_cap(ctrl_reg[2])
        && !(bus_reg == B_WR && adr_reg.chan == 3'h2)
        |=> val_reg[2] == $past(val_reg[2]))
        else $error("capture taken while blocked");

    a_cmp_block: assert property (
        cmp_blk_reg[0] && ctrl_reg[0].mode_select_a && !ctrl_reg[0].buffered_mode_select
        && ctrl_reg[0].edge_level != EL_NONE && !cnt_ovf && !fdty_reg[0]
        |=> $stable(chan_pin_out[0]))
        else $error("compare acted while blocked");

    a_ovf_wins: assert property (
        is_cmp(ctrl_reg[0]) && ctrl_reg[0].toggle_on_overflow && cnt_ovf
        |=> chan_pin_out[0] != $past(chan_pin_out[0]))
        else $error("overflow toggle missing");

    a_full_duty: assert property (
        fdty_reg[0] && is_cmp(ctrl_reg[0]) && ctrl_reg[0].edge_level == EL_FALL_CLR
        && !cnt_ovf |=> chan_pin_out[0])
        else $error("full duty not held");

    a_event_flag: assert property (
        cap_ev[0] || cmp_ev[0] |=> ctrl_reg[0].chan_event_flag)
        else $error("event did not set flag");

    a_flag_hold: assert property (
        $fell(ctrl_reg[0].chan_event_flag) |-> $past(wr_ctrl0))
        else $error("flag cleared without a control write");

endmodule

`default_nettype wire

/* File: rtl/tcc_pkg.sv */
// Purpose: shared constants and types of the timer channel block
// Assumes: AHB-Lite word registers, six channels in three pairs
// Notes:   channel x registers sit at byte x*16 + offset
package tcc_pkg;

    localparam int         NUM_CHAN    = 6;
    localparam int         NUM_PAIR    = 3;
    localparam int         VAL_W       = 16;
    localparam logic [2:0] CHAN_LAST   = 3'h5;
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] VHI_OFS     = 4'h4;
    localparam logic [3:0] VLO_OFS     = 4'h8;
    localparam logic [1:0] EL_NONE     = 2'h0;
    localparam logic [1:0] EL_RISE_TGL = 2'h1;
    localparam logic [1:0] EL_FALL_CLR = 2'h2;
    localparam logic [1:0] EL_ANY_SET  = 2'h3;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       chan_event_flag;
        logic       chan_irq_enable;
        logic       buffered_mode_select;
        logic       mode_select_a;
        logic [1:0] edge_level;
        logic       toggle_on_overflow;
        logic       force_full_duty;
    } ctrl_type;

    localparam ctrl_type CTRL_RST = 8'h00;

    typedef struct packed {
        logic [2:0] chan;
        logic [3:0] ofs;
    } addr_type;

    typedef enum {B_IDLE, B_WR, B_RD} bus_state_type;

    function automatic logic is_cap(ctrl_type c);
        return !c.buffered_mode_select && !c.mode_select_a && c.edge_level != EL_NONE;
    endfunction

    function automatic logic is_cmp(ctrl_type c);
        return (c.buffered_mode_select || c.mode_select_a) && c.edge_level != EL_NONE;
    endfunction

endpackage

/* File: dv/chan_pin_partner.sv */
// Purpose: far side of the six timer channel pins
// Assumes: bench sets the level wanted on each pin the channel leaves free
// Notes:   a pin the channel owns follows the channel drive, never the bench
`timescale 1ns/100ps
`default_nettype none

module chan_pin_partner
    import tcc_pkg::*;
(
    input  wire logic [NUM_CHAN-1:0] ext_level,    // far-side wanted level
    input  wire logic [NUM_CHAN-1:0] chan_pin_out, // channel drive level
    input  wire logic [NUM_CHAN-1:0] chan_pin_oe,  // channel owns pin
    output logic      [NUM_CHAN-1:0] pin_level     // resolved pin level
);

    // far side lets go of every pin the channel drives
    assign pin_level = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & ext_level);

endmodule

`default_nettype wire

/* File: dv/timer_channel_capture_compare_tb.sv */
// Purpose: self-checking bench of the timer capture/compare channels
// Assumes: one AHB-Lite master, hready wired to hreadyout
// Notes:   random counter and compare values from a fixed xorshift seed
`timescale 1ns/100ps
`default_nettype none

module timer_channel_capture_compare_tb;
    import tcc_pkg::*;

    logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic                cnt_tick, cnt_ovf, counter_halt, e;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr, hwdata, hrdata, q, rs;
    logic [VAL_W-1:0]    cnt_value, v, v2;
    logic [NUM_CHAN-1:0] ext_level, pin_level, chan_pin_out, chan_pin_oe, chan_irq;
    int                  n_fail, total_checks;

    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;

    timer_channel_capture_compare DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cnt_value(cnt_value), .cnt_tick(cnt_tick), .cnt_ovf(cnt_ovf),
        .counter_halt(counter_halt), .chan_pin_in(pin_level),
        .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq));

    chan_pin_partner far_side (.ext_level(ext_level), .chan_pin_out(chan_pin_out),
        .chan_pin_oe(chan_pin_oe), .pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic cmp_level(input logic [1:0] els, input logic prev);
        return (els == EL_RISE_TGL) ? ~prev : (els == EL_ANY_SET);
    endfunction

    function automatic logic cap_hit(input logic [1:0] els, input logic rise);
        return rise ? els[0] : els[1];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // one edge with hready high, bounded
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 40);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {25'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata;
    endtask

    task automatic rd(input int ch, input int ofs, input logic [7:0] exp);
        bus(1'b0, 7'(ch * 16 + ofs), 8'h00);
        chk(q, {24'h0, exp});
        chk(32'(hresp), 32'h0);
    endtask

    // counter held stopped around a change of function
    task automatic mode(input int ch, input logic [7:0] c);
        counter_halt <= 1'b1;
        bus(1'b1, 7'(ch * 16), c);
        counter_halt <= 1'b0;
        // control lands at the data edge, pin outputs one edge later
        repeat (2) @(posedge hclk);
    endtask

    task automatic setval(input int ch, input logic [15:0] x);
        bus(1'b1, 7'(ch * 16 + 4), x[15:8]);
        bus(1'b1, 7'(ch * 16 + 8), x[7:0]);
    endtask

    task automatic tick(input logic [15:0] x, input logic ovf);
        cnt_value <= x;
        cnt_tick  <= 1'b1;
        cnt_ovf   <= ovf;
        @(posedge hclk);
        cnt_tick  <= 1'b0;
        cnt_ovf   <= 1'b0;
        @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; cnt_value = 16'h0;
        cnt_tick = 1'b0; cnt_ovf = 1'b0; counter_halt = 1'b0; ext_level = 6'h00;
        n_fail = 0; total_checks = 0; rs = 32'h78184544;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int ch = 0; ch < NUM_CHAN; ch++) rd(ch, 0, 8'h00);
        chk(32'({chan_pin_out, chan_pin_oe, chan_irq}), 32'h3f000);
        rd(6, 0, 8'h00);
        rd(0, 12, 8'h00);
        mode(1, 8'h20);
        rd(1, 0, 8'h00);
        // unbuffered compare, every edge/level action
        mode(0, 8'h10);
        chk(32'({chan_pin_oe[0], chan_pin_out[0]}), 32'h0);
        e = 1'b0;
        for (int els = 1; els < 4; els++) begin
            rs = xs(rs);
            v = rs[15:0];
            setval(0, v);
            mode(0, 8'h50 | 8'(els << 2));
            tick(v, 1'b0);
            e = cmp_level(2'(els), e);
            chk(32'({chan_pin_oe[0], chan_pin_out[0], chan_irq[0]}), {30'h0, e, 1'b1} | 32'h4);
            rd(0, 0, 8'hd0 | 8'(els << 2));
            bus(1'b1, 7'h00, 8'h50 | 8'(els << 2));
            rd(0, 0, 8'h50 | 8'(els << 2));
            chk(32'(chan_irq[0]), 32'h0);
        end
        // compare suppressed between high and low byte writes
        mode(0, 8'h54);
        rs = xs(rs);
        v2 = rs[15:0];
        bus(1'b1, 7'h04, v2[15:8]);
        tick({v2[15:8], v[7:0]}, 1'b0);
        tick(v, 1'b0);
        rd(0, 0, 8'h54);
        bus(1'b1, 7'h08, v2[7:0]);
        tick(v2, 1'b0);
        e = ~e;
        chk(32'(chan_pin_out[0]), 32'(e));
        // overflow toggle beats a clearing compare
        mode(0, 8'h1a);
        tick(v2, 1'b1);
        e = ~e;
        chk(32'(chan_pin_out[0]), 32'(e));
        // full duty from the next period on
        mode(0, 8'h19);
        tick(v2 ^ 16'h0f00, 1'b1);
        tick(v2, 1'b0);
        chk(32'(chan_pin_out[0]), 32'h1);
        mode(0, 8'h18);
        tick(v2 ^ 16'h0f00, 1'b1);
        tick(v2, 1'b0);
        chk(32'(chan_pin_out[0]), 32'h0);
        // input capture on channel 2, pin settled low first
        ext_level[2] <= 1'b0;
        repeat (3) @(posedge hclk);
        for (int els = 1; els < 4; els++) begin
            mode(2, 8'(els << 2));
            chk(32'(chan_pin_oe[2]), 32'h0);
            for (int r = 1; r >= 0; r--) begin
                rs = xs(rs);
                v = rs[15:0];
                cnt_value <= v;
                ext_level[2] <= r[0];
                repeat (8) @(posedge hclk);
                rd(2, 0, {cap_hit(2'(els), r[0]), 7'(els << 2)});
                if (cap_hit(2'(els), r[0])) begin
                    rd(2, 4, v[15:8]);
                    rd(2, 8, v[7:0]);
                end
                bus(1'b1, 7'h20, 8'(els << 2));
            end
        end
        // high byte read holds off captures until the low byte read
        bus(1'b0, 7'h24, 8'h00);
        ext_level[2] <= 1'b1;
        repeat (8) @(posedge hclk);
        rd(2, 0, 8'h0c);
        bus(1'b0, 7'h28, 8'h00);
        ext_level[2] <= 1'b0;
        repeat (8) @(posedge hclk);
        rd(2, 0, 8'h8c);
        // buffered pair 4/5
        mode(5, 8'h14);
        chk(32'(chan_pin_oe[5]), 32'h1);
        rs = xs(rs);
        v = rs[15:0];
        setval(4, v);
        setval(5, ~v);
        mode(4, 8'h2c);
        rd(4, 0, 8'h2c);
        rd(5, 0, 8'h00);
        chk(32'({chan_pin_oe[5], chan_pin_oe[4]}), 32'h1);
        tick(v ^ 16'h0f00, 1'b1);
        tick(v, 1'b0);
        rd(4, 0, 8'h2c);
        tick(~v, 1'b0);
        rd(4, 0, 8'hac);
        test_done();
    end

endmodule

`default_nettype wire
